// ==== dpjp_pkg.sv ====
// Shared constants, types and address decode for the dual printer and game port block
package dpjp_pkg;

  localparam int CLK_MHZ = 100;

  // I/O map, ten-bit addresses; alternates chosen by jumper straps
  localparam logic [9:0] LPT0_BASE_DEF = 10'h378;
  localparam logic [9:0] LPT0_BASE_ALT = 10'h3bc;
  localparam logic [9:0] LPT1_BASE_DEF = 10'h278;
  localparam logic [9:0] LPT1_BASE_ALT = 10'h2bc;
  localparam logic [9:0] GAME_BASE_DEF = 10'h200;
  localparam logic [9:0] GAME_BASE_ALT = 10'h208;

  // Register offsets inside a printer port
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_STAT = 2'h1;
  localparam logic [1:0] OFS_CTRL = 2'h2;

  // Decode targets
  localparam logic [1:0] SEL_LPT0 = 2'h0;
  localparam logic [1:0] SEL_LPT1 = 2'h1;
  localparam logic [1:0] SEL_GAME = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // Control register fields: bits 3:0 assert strobe, line feed, init, select
  localparam int CTL_IEN = 4;
  localparam int CTL_DIR = 5;
  localparam int CTL_W   = 6;
  localparam logic [CTL_W-1:0] CTL_RST  = 6'h00;
  localparam logic [7:0]       DATA_RST = 8'h00;

  // Status input order {busy, ack, paper empty, select, error}
  localparam int STI_ACK = 3;

  // Sync reset levels {straps, route, status, control, data}: pulled-up lines idle high,
  // so a zero here would fake an acknowledge edge when reset ends
  localparam logic [40:0] PIN_IDLE = {7'h00, 18'h3ffff, 16'h0000};

  // Jumper strap positions
  localparam int JMP_LPT0 = 0;
  localparam int JMP_LPT1 = 1;
  localparam int JMP_GAME = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Longest axis pulse before the bit is forced low
  localparam int AXIS_TIMEOUT_US  = 2000;
  localparam int AXIS_TIMEOUT_CYC = AXIS_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} dpjp_wr_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} dpjp_rd_t;

  // Returns {target, offset} for a ten-bit I/O address
  function automatic logic [3:0] io_decode(input logic [9:0] a, input logic [2:0] alt);
    logic [9:0] b0;
    logic [9:0] b1;
    logic [9:0] bg;
    b0 = alt[JMP_LPT0] ? LPT0_BASE_ALT : LPT0_BASE_DEF;
    b1 = alt[JMP_LPT1] ? LPT1_BASE_ALT : LPT1_BASE_DEF;
    bg = alt[JMP_GAME] ? GAME_BASE_ALT : GAME_BASE_DEF;
    io_decode = {SEL_NONE, 2'h0};
    if (a[9:2] == b0[9:2] && a[1:0] != 2'h3) begin
      io_decode = {SEL_LPT0, a[1:0]};
    end else if (a[9:2] == b1[9:2] && a[1:0] != 2'h3) begin
      io_decode = {SEL_LPT1, a[1:0]};
    end else if (a[9:1] == bg[9:1]) begin
      io_decode = {SEL_GAME, 2'h0};
    end
  endfunction

endpackage

// ==== dpjp_game_if.sv ====
// Link between the register front end and the game port timer
interface dpjp_game_if;
  logic       trig;
  logic [7:0] stat;
  modport host (output trig, input stat);
  modport game (input trig, output stat);
endinterface

// ==== dpjp_game_port.sv ====
// Game port: four axis one-shots and four button inputs
module dpjp_game_port
  import dpjp_pkg::*;
#(
  parameter int TIMEOUT_CYC = AXIS_TIMEOUT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  dpjp_game_if.game       gp,
  input  wire logic [3:0] button_n,
  input  wire logic [3:0] axis_cmp,
  output logic      [3:0] axis_run
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] TO_LIM = CW'(TIMEOUT_CYC);

  logic [7:0]    meta_q;
  logic [7:0]    sync_q;
  logic [3:0]    run_q;
  logic [CW-1:0] cnt_q;

  // Buttons idle high through their pull-ups
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= 8'hf0;
      sync_q <= 8'hf0;
    end else begin
      meta_q <= {button_n, axis_cmp};
      sync_q <= meta_q;
    end
  end

  // Trigger sets all axes; a comparator that has tripped ends its pulse
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      run_q <= 4'h0;
    end else if (gp.trig) begin
      run_q <= 4'hf;
    end else begin
      run_q <= run_q & ~sync_q[3:0] & {4{cnt_q != TO_LIM}};
    end
  end

  // Timeout guards against a missing stick keeping the bit high forever
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (gp.trig) begin
      cnt_q <= '0;
    end else if (|run_q && cnt_q != TO_LIM) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign gp.stat  = {sync_q[7:4], run_q};
  assign axis_run = run_q;

  trig_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    gp.trig |=> run_q == 4'hf)
    else $error("axis pulse not started by trigger");

  run_limit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cnt_q == TO_LIM && !gp.trig) |=> run_q == 4'h0)
    else $error("axis pulse outlived timeout");

  button_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(resetn, 2) |-> gp.stat[7:4] == $past(button_n, 2))
    else $error("button bits do not follow pins");

endmodule // dpjp_game_port

// ==== dpjp_top.sv ====
// Dual printer port and game port block behind an AXI4-Lite slave
// Overview of operation
// - Ten address bits decoded; printer ports sit at standard PC locations by default
// - Game port answers at I/O addresses 200h and 201h by default
// - Jumper straps move each function to an alternate base address
// - Two identical printer ports work fully independently
// - Each port has an 8-bit data register usable in both directions
// - A written data byte reads back unchanged while the port is in output mode; input mode reads the pins
// - Four open-collector control outputs: line feed, init, select, strobe
// - Host reads back the inverse of the present level of the four control lines
// - Input-only status reports error, acknowledge, busy, paper empty, select
// - Acknowledge activity raises the port's interrupt request
// - Each port's interrupt is gated by a software enable bit
// - Each printer interrupt routes to one of three backplane request lines, or to none
// - Game port reads X and Y position of two joysticks
// - Each joystick provides two readable buttons
// - Four button lines stay readable as plain inputs
module dpjp_top
  import dpjp_pkg::*;
#(
  parameter int AW          = 12,
  parameter int TIMEOUT_CYC = AXIS_TIMEOUT_CYC
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [AW-1:0]    s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [AW-1:0]    s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [2:0]       jumper_alt,
  input  wire logic [3:0]       irq_route,
  input  wire logic [1:0][7:0]  lpt_data_in,
  output logic      [1:0][7:0]  lpt_data_out,
  output logic      [1:0]       lpt_data_oe_n,
  input  wire logic [1:0][3:0]  lpt_ctl_in,
  output logic      [1:0][3:0]  lpt_ctl_out,
  output logic      [1:0][3:0]  lpt_ctl_oe_n,
  input  wire logic [1:0][4:0]  lpt_stat_in,
  output logic      [2:0]       backplane_irq_line,
  input  wire logic [3:0]       button_n,
  input  wire logic [3:0]       axis_cmp,
  output logic      [3:0]       axis_run
);

  // Pin and strap synchronisers
  logic [40:0]      in_meta_q;
  logic [40:0]      in_sync_q;
  logic [2:0]       alt_s;
  logic [3:0]       route_s;
  logic [1:0][4:0]  stat_s;
  logic [1:0][3:0]  ctl_s;
  logic [1:0][7:0]  data_s;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      in_meta_q <= PIN_IDLE;
      in_sync_q <= PIN_IDLE;
    end else begin
      in_meta_q <= {jumper_alt, irq_route, lpt_stat_in, lpt_ctl_in, lpt_data_in};
      in_sync_q <= in_meta_q;
    end
  end

  assign {alt_s, route_s, stat_s, ctl_s, data_s} = in_sync_q;

  // Port state
  logic [1:0][7:0]       data_q;
  logic [1:0][CTL_W-1:0] ctl_q;
  logic [1:0]            pend_q;
  logic [1:0]            ack_prev_q;
  logic [1:0]            ack_rise;
  logic [1:0]            irq_req;
  logic [1:0]            rd_stat_clr;
  logic [2:0]            irq_q;
  logic [2:0]            irq_d;

  // Write channel
  dpjp_wr_t    wr_state_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [9:0]  aw_io_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic        wr_do;
  logic [3:0]  wr_dec;

  assign s_axi_awready = (wr_state_q == WR_COLLECT) && !aw_have_q;
  assign s_axi_wready  = (wr_state_q == WR_COLLECT) && !w_have_q;
  assign wr_do         = (wr_state_q == WR_COLLECT) && aw_have_q && w_have_q;
  assign wr_dec        = io_decode(aw_io_q, alt_s);

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      aw_io_q   <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_io_q   <= s_axi_awaddr[11:2];
    end else if (wr_do) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_do) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_state_q <= WR_COLLECT;
      bresp_q    <= RESP_OKAY;
    end else begin
      unique case (wr_state_q)
        WR_COLLECT: begin
          if (wr_do) begin
            wr_state_q <= WR_RESP;
            bresp_q    <= (wr_dec[3:2] == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= WR_COLLECT;
          end
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state_q == WR_RESP);
  assign s_axi_bresp  = bresp_q;

  // Printer port registers, one loop keeps both instances identical
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_q <= {2{DATA_RST}};
      ctl_q  <= {2{CTL_RST}};
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (wr_do && wstrb_q[0] && wr_dec[3:2] == 2'(p)) begin
          if (wr_dec[1:0] == OFS_DATA) begin
            data_q[p] <= wdata_q[7:0];
          end
          if (wr_dec[1:0] == OFS_CTRL) begin
            ctl_q[p] <= wdata_q[CTL_W-1:0];
          end
        end
      end
    end
  end

  // Acknowledge edge is caught as pending; a status read clears it, a new edge wins
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ack_prev_q <= 2'h3;
      pend_q     <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        ack_prev_q[p] <= stat_s[p][STI_ACK];
        if (ack_rise[p]) begin
          pend_q[p] <= 1'b1;
        end else if (rd_stat_clr[p]) begin
          pend_q[p] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    irq_d = 3'h0;
    for (int p = 0; p < 2; p++) begin
      ack_rise[p] = stat_s[p][STI_ACK] && !ack_prev_q[p];
      irq_req[p]  = pend_q[p] && ctl_q[p][CTL_IEN];
      for (int k = 0; k < 3; k++) begin
        if (irq_req[p] && route_s[2*p +: 2] == 2'(k)) begin
          irq_d[k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_q <= 3'h0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign backplane_irq_line = irq_q;

  // Pins: data drives unless turned round; control lines only pull low
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      lpt_data_out[p]  = data_q[p];
      lpt_data_oe_n[p] = ctl_q[p][CTL_DIR];
      lpt_ctl_out[p]   = 4'h0;
      lpt_ctl_oe_n[p]  = ~ctl_q[p][3:0];
    end
  end

  // Game port
  dpjp_game_if gp_bus ();

  assign gp_bus.trig = wr_do && wstrb_q[0] && (wr_dec[3:2] == SEL_GAME);

  dpjp_game_port #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_game (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .gp       (gp_bus.game),
    .button_n (button_n),
    .axis_cmp (axis_cmp),
    .axis_run (axis_run)
  );

  // Read channel
  dpjp_rd_t    rd_state_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rd_take;
  logic [3:0]  rd_dec;
  logic [7:0]  rd_val;
  logic        rd_ok;

  assign s_axi_arready = (rd_state_q == RD_IDLE);
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rd_dec        = io_decode(s_axi_araddr[11:2], alt_s);

  always_comb begin
    logic idx;
    idx    = rd_dec[2];
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    unique case (rd_dec[3:2])
      SEL_LPT0, SEL_LPT1: begin
        unique case (rd_dec[1:0])
          // Output mode returns the latch so a pin fight cannot hide the written byte
          OFS_DATA: rd_val = ctl_q[idx][CTL_DIR] ? data_s[idx] : data_q[idx];
          OFS_STAT: rd_val = {stat_s[idx], pend_q[idx], 2'b00};
          OFS_CTRL: rd_val = {2'b00, ctl_q[idx][CTL_DIR:CTL_IEN], ~ctl_s[idx]};
          default:  rd_val = 8'h00;
        endcase
      end
      SEL_GAME: rd_val = gp_bus.stat;
      SEL_NONE: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rd_stat_clr[p] = rd_take && rd_dec[3:2] == 2'(p) && rd_dec[1:0] == OFS_STAT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_state_q <= RD_IDLE;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
    end else begin
      unique case (rd_state_q)
        RD_IDLE: begin
          if (rd_take) begin
            rd_state_q <= RD_RESP;
            rdata_q    <= {24'h00_0000, rd_val};
            rresp_q    <= rd_ok ? RESP_OKAY : RESP_DECERR;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_q <= RD_IDLE;
          end
        end
      endcase
    end
  end

  assign s_axi_rvalid = (rd_state_q == RD_RESP);
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Checks
  sequence wr_unmapped_s;
    wr_do && wr_dec[3:2] == SEL_NONE;
  endsequence

  sequence rd_lpt0_data_s;
    rd_take && rd_dec[3:2] == SEL_LPT0 && rd_dec[1:0] == OFS_DATA && !ctl_q[0][CTL_DIR];
  endsequence

  ctl_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !resetn |=> ctl_q == {2{CTL_RST}} && lpt_ctl_oe_n == 8'hff)
    else $error("control outputs not released by reset");

  unmapped_err_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_unmapped_s |=> s_axi_bvalid && s_axi_bresp == RESP_DECERR)
    else $error("unmapped write not refused");

  data_readback_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_lpt0_data_s |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(data_q[0]))
    else $error("data readback differs from written byte");

  game_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_take && !alt_s[JMP_GAME] && s_axi_araddr[11:3] == GAME_BASE_DEF[9:1])
      |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[7:0] == $past(gp_bus.stat))
    else $error("game port not at default address");

  ack_pend_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ack_rise[1] |=> pend_q[1])
    else $error("acknowledge edge lost");

  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ctl_q[0][CTL_IEN] && !ctl_q[1][CTL_IEN]) |=> backplane_irq_line == 3'h0)
    else $error("interrupt raised while disabled");

  irq_route_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (irq_req[0] && route_s[1:0] == 2'h1) |=> backplane_irq_line[1])
    else $error("interrupt not on routed line");

endmodule // dpjp_top

// ==== dpjp_periph_model.sv ====
// Printer, parallel peripheral and joystick model on the far side of the pins
module dpjp_periph_model (
  input  wire logic            ref_clk,
  input  wire logic [1:0][7:0] lpt_data_out,
  input  wire logic [1:0]      lpt_data_oe_n,
  input  wire logic [1:0][3:0] lpt_ctl_oe_n,
  input  wire logic [3:0]      axis_run,
  input  wire logic [1:0][7:0] drv_data,
  input  wire logic [1:0]      drv_en,
  input  wire logic [1:0][4:0] stat,
  input  wire logic [3:0]      pressed,
  input  wire logic [3:0][7:0] axis_dly,
  output logic      [1:0][7:0] lpt_data_in,
  output logic      [1:0][3:0] lpt_ctl_in,
  output logic      [1:0][4:0] lpt_stat_in,
  output logic      [3:0]      button_n,
  output logic      [3:0]      axis_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0][7:0] cnt_q;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      // Undriven lines show the inverse of the last value, not a stale copy
      if (!lpt_data_oe_n[p]) begin
        lpt_data_in[p] = lpt_data_out[p];
      end else if (drv_en[p]) begin
        lpt_data_in[p] = drv_data[p];
      end else begin
        lpt_data_in[p] = ~lpt_data_out[p];
      end
    end
  end
  // Open collector with pull-up: low only while pulled
  assign lpt_ctl_in  = lpt_ctl_oe_n;
  assign lpt_stat_in = stat;
  // Switch closure to ground against a pull-up
  assign button_n    = ~pressed;
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt_q[i] <= axis_run[i] ? cnt_q[i] + 8'h01 : 8'h00;
    end
  end
  // A delay of zero models an unplugged stick that never reaches threshold
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      axis_cmp[i] = axis_run[i] && axis_dly[i] != 8'h00 && cnt_q[i] >= axis_dly[i];
    end
  end
endmodule // dpjp_periph_model

// ==== dual_printer_joystick_port_bench.sv ====
// Self-checking bench for the dual printer and game port block
module dual_printer_joystick_port_bench
  import dpjp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            ref_clk = 1'b0;
  logic            resetn;
  logic [11:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready;
  logic [2:0]      jumper_alt, backplane_irq_line;
  logic [3:0]      irq_route, button_n, axis_cmp, axis_run, pressed;
  logic [1:0][7:0] lpt_data_in, lpt_data_out, drv_data;
  logic [1:0]      lpt_data_oe_n, drv_en;
  logic [1:0][3:0] lpt_ctl_in, lpt_ctl_out, lpt_ctl_oe_n;
  logic [1:0][4:0] lpt_stat_in, stat;
  logic [3:0][7:0] axis_dly;
  int              err_count = 0;
  int              total_checks = 0;
  int              cycles = 0;

  dpjp_top #(.AW(12), .TIMEOUT_CYC(50)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .jumper_alt(jumper_alt), .irq_route(irq_route),
    .lpt_data_in(lpt_data_in), .lpt_data_out(lpt_data_out), .lpt_data_oe_n(lpt_data_oe_n),
    .lpt_ctl_in(lpt_ctl_in), .lpt_ctl_out(lpt_ctl_out), .lpt_ctl_oe_n(lpt_ctl_oe_n),
    .lpt_stat_in(lpt_stat_in), .backplane_irq_line(backplane_irq_line),
    .button_n(button_n), .axis_cmp(axis_cmp), .axis_run(axis_run));

  dpjp_periph_model far_end (
    .ref_clk(ref_clk), .lpt_data_out(lpt_data_out), .lpt_data_oe_n(lpt_data_oe_n),
    .lpt_ctl_oe_n(lpt_ctl_oe_n), .axis_run(axis_run), .drv_data(drv_data), .drv_en(drv_en),
    .stat(stat), .pressed(pressed), .axis_dly(axis_dly), .lpt_data_in(lpt_data_in),
    .lpt_ctl_in(lpt_ctl_in), .lpt_stat_in(lpt_stat_in), .button_n(button_n),
    .axis_cmp(axis_cmp));

  always #5 ref_clk = ~ref_clk;

  task automatic stop_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Sample handshakes at the falling edge; their level holds up to the next rising edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, ta, tw, b_ok;
    logic [1:0] resp;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge ref_clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (!b_ok) begin
      @(negedge ref_clk);
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
    end
    s_axi_bready <= 1'b0;
    chk({6'h00, resp}, {6'h00, er});
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] ex, input logic [1:0] er);
    logic ta, done;
    logic [7:0] d;
    logic [1:0] resp;
    done = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge ref_clk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) begin
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
    chk(d, ex);
    chk({6'h00, resp}, {6'h00, er});
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
    jumper_alt = 3'h0;
    irq_route = 4'h9;
    drv_data = '0;
    drv_en = '0;
    stat = '0;
    pressed = 4'h9;
    axis_dly = {8'h00, 8'h28, 8'h14, 8'h0a};
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk(lpt_ctl_oe_n, 8'hff);
    chk({1'b0, backplane_irq_line, axis_run}, 8'h00);
    wr(LPT0_BASE_DEF, 8'h3c, RESP_OKAY);
    wr(LPT1_BASE_DEF, 8'hc3, RESP_OKAY);
    rd(LPT0_BASE_DEF, 8'h3c, RESP_OKAY);
    rd(LPT1_BASE_DEF, 8'hc3, RESP_OKAY);
    chk(lpt_data_out[0], 8'h3c);
    chk(lpt_data_out[1], 8'hc3);
    rd(LPT0_BASE_DEF + 10'h003, 8'h00, RESP_DECERR);
    wr(10'h3ff, 8'h00, RESP_DECERR);
    s_axi_wstrb <= 4'h0;
    wr(LPT0_BASE_DEF, 8'hff, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    jumper_alt <= 3'h7;
    repeat (4) @(posedge ref_clk);
    rd(LPT0_BASE_ALT, 8'h3c, RESP_OKAY);
    rd(LPT1_BASE_ALT, 8'hc3, RESP_OKAY);
    rd(LPT0_BASE_DEF, 8'h00, RESP_DECERR);
    rd(GAME_BASE_DEF, 8'h00, RESP_DECERR);
    rd(GAME_BASE_ALT + 10'h001, 8'h60, RESP_OKAY);
    jumper_alt <= 3'h0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      wr(LPT0_BASE_DEF + 10'h002, 8'h20 | (8'h01 << i), RESP_OKAY);
      chk(lpt_ctl_oe_n[0], ~(8'hf0 | (8'h01 << i)));
      repeat (3) @(posedge ref_clk);
      rd(LPT0_BASE_DEF + 10'h002, 8'h20 | (8'h01 << i), RESP_OKAY);
    end
    drv_data[0] <= 8'h5a;
    drv_en[0] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({7'h00, lpt_data_oe_n[0]}, 8'h01);
    rd(LPT0_BASE_DEF, 8'h5a, RESP_OKAY);
    rd(LPT1_BASE_DEF, 8'hc3, RESP_OKAY);
    wr(LPT1_BASE_DEF + 10'h002, 8'h0a, RESP_OKAY);
    chk({lpt_ctl_oe_n[0], lpt_ctl_oe_n[1]}, 8'h75);
    chk(lpt_ctl_out, 8'h00);
    wr(LPT0_BASE_DEF + 10'h002, 8'h30, RESP_OKAY);
    stat[0] <= 5'h08;
    repeat (8) @(posedge ref_clk);
    chk({5'h00, backplane_irq_line}, 8'h02);
    rd(LPT0_BASE_DEF + 10'h001, 8'h44, RESP_OKAY);
    repeat (6) @(posedge ref_clk);
    chk({5'h00, backplane_irq_line}, 8'h00);
    stat[1] <= 5'h08;
    repeat (8) @(posedge ref_clk);
    chk({5'h00, backplane_irq_line}, 8'h00);
    rd(LPT1_BASE_DEF + 10'h001, 8'h44, RESP_OKAY);
    stat[0] <= 5'h1f;
    wr(LPT1_BASE_DEF + 10'h002, 8'h1f, RESP_OKAY);
    stat[1] <= 5'h00;
    repeat (4) @(posedge ref_clk);
    stat[1] <= 5'h08;
    repeat (8) @(posedge ref_clk);
    chk({5'h00, backplane_irq_line}, 8'h04);
    irq_route <= 4'h3;
    repeat (5) @(posedge ref_clk);
    chk({5'h00, backplane_irq_line}, 8'h01);
    rd(LPT0_BASE_DEF + 10'h001, 8'hf8, RESP_OKAY);
    wr(GAME_BASE_DEF + 10'h001, 8'h00, RESP_OKAY);
    rd(GAME_BASE_DEF + 10'h001, 8'h6f, RESP_OKAY);
    chk({4'h0, axis_run}, 8'h0f);
    repeat (24) @(posedge ref_clk);
    rd(GAME_BASE_DEF, 8'h6c, RESP_OKAY);
    repeat (40) @(posedge ref_clk);
    rd(GAME_BASE_DEF + 10'h001, 8'h60, RESP_OKAY);
    pressed <= 4'h6;
    repeat (3) @(posedge ref_clk);
    rd(GAME_BASE_DEF, 8'h90, RESP_OKAY);
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk(lpt_ctl_oe_n, 8'hff);
    chk({5'h00, backplane_irq_line}, 8'h00);
    repeat (3) @(posedge ref_clk);
    rd(LPT1_BASE_DEF + 10'h002, 8'h00, RESP_OKAY);
    rd(LPT0_BASE_DEF + 10'h001, 8'hf8, RESP_OKAY);
    stop_test();
  end
endmodule // dual_printer_joystick_port_bench
